/* File: hw/on_chip_data_ram_pkg.sv */
// package: register map, field layout and bus carriers of the external data ram mapper
package on_chip_data_ram_pkg;
    localparam int ON_CHIP_DATA_RAM_BYTES = 1024;
    localparam int ON_CHIP_DATA_RAM_AW = 10;
    localparam logic [7:0] ON_CHIP_DATA_RAM_PAGE_CONTROL_ADDR = 8'haf;
    localparam logic [7:0] ON_CHIP_DATA_RAM_PAGE_CONTROL_RESET = 8'h00;
    localparam int ON_CHIP_DATA_RAM_PAGE_SEL_LSB = 0;
    localparam int ON_CHIP_DATA_RAM_PAGE_SEL_W = 2;
    localparam logic [7:0] ON_CHIP_DATA_RAM_PAGE_CONTROL_MASK = 8'h03;

    // one external data move from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic short_addr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } on_chip_data_ram_move_s;

    // special function register access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } on_chip_data_ram_sfr_s;
endpackage

/* File: hw/on_chip_data_ram_byte_store.sv */
// byte-wide flip-flop storage with synchronous write and registered read
`timescale 1ns/1ps
module on_chip_data_ram_byte_store #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    // contents are not cleared by reset
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (re_i)
        begin
            rdata_q <= mem_q[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule

/* File: hw/on_chip_data_ram_access_mapper.sv */
// top: on-chip data ram in the external data space, page select register, flash yield
//
// Operation
// - provide 1024 bytes of storage in the external data space
// - every byte readable and writable by pointer or indirect moves
// - short-operand moves take upper address byte from page control register
// - moves target ram when program store select is zero; writes otherwise go to flash
// - address bits above the ten index bits are ignored in every mode
// - ram repeats modulo 1024 across the whole 64 KB range
`timescale 1ns/1ps
module on_chip_data_ram_access_mapper #(
    parameter int DEPTH = on_chip_data_ram_pkg::ON_CHIP_DATA_RAM_BYTES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire on_chip_data_ram_pkg::on_chip_data_ram_move_s move_i,
    input wire logic program_store_write_select_i,
    input wire on_chip_data_ram_pkg::on_chip_data_ram_sfr_s sfr_i,
    output logic [7:0] move_rdata_o,
    output logic move_rvalid_o,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o
);
    import on_chip_data_ram_pkg::*;

    // ******************************************
    // move fields
    // ******************************************
    logic move_rd;
    logic move_wr;
    logic move_short;
    logic [15:0] move_addr;
    logic [7:0] move_wdata;

    assign move_rd = move_i.rd;
    assign move_wr = move_i.wr;
    assign move_short = move_i.short_addr;
    assign move_addr = move_i.addr;
    assign move_wdata = move_i.wdata;

    // ******************************************
    // register access fields
    // ******************************************
    logic sfr_rd;
    logic sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;

    assign sfr_rd = sfr_i.rd;
    assign sfr_wr = sfr_i.wr;
    assign sfr_addr = sfr_i.addr;
    assign sfr_wdata = sfr_i.wdata;

    // ******************************************
    // register address decode
    // ******************************************
    logic page_control_sel;

    // other register addresses belong to other blocks
    always_comb
    begin
        if (sfr_addr == ON_CHIP_DATA_RAM_PAGE_CONTROL_ADDR)
        begin
            page_control_sel = 1'b1;
        end
        else
        begin
            page_control_sel = 1'b0;
        end
    end

    assign sfr_hit_o = page_control_sel;

    // ******************************************
    // page control register
    // ******************************************
    logic [ON_CHIP_DATA_RAM_PAGE_SEL_W-1:0] ram_page_select_q;
    logic [ON_CHIP_DATA_RAM_PAGE_SEL_W-1:0] ram_page_select_d;
    logic page_control_we;

    assign page_control_we = sfr_wr && page_control_sel;

    always_comb
    begin
        ram_page_select_d = ram_page_select_q;
        if (page_control_we)
        begin
            // bits above the page field are read-only
            ram_page_select_d = sfr_wdata[ON_CHIP_DATA_RAM_PAGE_SEL_LSB +: ON_CHIP_DATA_RAM_PAGE_SEL_W];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ram_page_select_q <= ON_CHIP_DATA_RAM_PAGE_CONTROL_RESET[ON_CHIP_DATA_RAM_PAGE_SEL_LSB +: ON_CHIP_DATA_RAM_PAGE_SEL_W];
        end
        else
        begin
            ram_page_select_q <= ram_page_select_d;
        end
    end

    // ******************************************
    // register read path
    // ******************************************
    logic [7:0] page_control_image;
    logic [7:0] sfr_rdata_d;
    logic [7:0] sfr_rdata_q;

    // unused bits fixed at zero
    always_comb
    begin
        page_control_image = 8'h00;
        page_control_image[ON_CHIP_DATA_RAM_PAGE_SEL_LSB +: ON_CHIP_DATA_RAM_PAGE_SEL_W] = ram_page_select_q;
    end

    always_comb
    begin
        if (!sfr_rd)
        begin
            sfr_rdata_d = sfr_rdata_q;
        end
        else if (page_control_sel)
        begin
            sfr_rdata_d = page_control_image & ON_CHIP_DATA_RAM_PAGE_CONTROL_MASK;
        end
        else
        begin
            sfr_rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sfr_rdata_q <= 8'h00;
        end
        else
        begin
            sfr_rdata_q <= sfr_rdata_d;
        end
    end

    assign sfr_rdata_o = sfr_rdata_q;

    // ******************************************
    // address formation
    // ******************************************
    logic [15:0] short_full_addr;
    logic [15:0] pointer_full_addr;
    logic [15:0] full_addr;

    // the register image is the whole upper byte, so bits 15-10 stay zero
    assign short_full_addr = {page_control_image, move_addr[7:0]};
    assign pointer_full_addr = move_addr;

    always_comb
    begin
        if (move_short)
        begin
            full_addr = short_full_addr;
        end
        else
        begin
            full_addr = pointer_full_addr;
        end
    end

    // ******************************************
    // modulo decode
    // ******************************************
    logic [ON_CHIP_DATA_RAM_AW-1:0] ram_index;

    // only the low ten bits index, so the ram aliases every 1 KB
    assign ram_index = full_addr[ON_CHIP_DATA_RAM_AW-1:0];

    // ******************************************
    // access qualification
    // ******************************************
    logic ram_we;
    logic ram_re;

    // flash takes writes when program store select is set
    always_comb
    begin
        if (program_store_write_select_i)
        begin
            ram_we = 1'b0;
        end
        else
        begin
            ram_we = move_wr;
        end
    end

    // reads stay on the ram whatever the select
    assign ram_re = move_rd;

    // ******************************************
    // byte storage
    // ******************************************
    on_chip_data_ram_byte_store #(
        .DEPTH(DEPTH),
        .AW(ON_CHIP_DATA_RAM_AW)
    ) u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(ram_we),
        .re_i(ram_re),
        .addr_i(ram_index),
        .wdata_i(move_wdata),
        .rdata_o(move_rdata_o)
    );

    // ******************************************
    // read valid
    // ******************************************
    logic rvalid_d;
    logic rvalid_q;

    assign rvalid_d = ram_re;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= rvalid_d;
        end
    end

    assign move_rvalid_o = rvalid_q;
endmodule

/* File: bench/on_chip_data_ram_sva.sv */
// checker: port timing of the mapper
`timescale 1ns/1ps
module on_chip_data_ram_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire on_chip_data_ram_pkg::on_chip_data_ram_move_s move_i,
    input wire on_chip_data_ram_pkg::on_chip_data_ram_sfr_s sfr_i,
    input wire logic move_rvalid_o,
    input wire logic [7:0] move_rdata_o,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_page_wr_rd;
        sfr_i.wr && sfr_hit_o ##1 sfr_i.rd && sfr_hit_o;
    endsequence
    a_read_answer: assert property (move_i.rd |=> move_rvalid_o) else $error("no rvalid");
    a_rvalid_cause: assert property (move_rvalid_o |-> $past(move_i.rd)) else $error("stray rvalid");
    a_sfr_decode: assert property (sfr_hit_o == (sfr_i.addr == 8'haf)) else $error("bad hit");
    a_page_echo: assert property (s_page_wr_rd |=> sfr_rdata_o == ($past(sfr_i.wdata, 2) & 8'h03))
        else $error("bad page");
    a_other_zero: assert property (sfr_i.rd && !sfr_hit_o |=> sfr_rdata_o == 8'h00) else $error("bad sfr");
    a_rdata_hold: assert property (!move_i.rd |=> $stable(move_rdata_o)) else $error("rdata moved");
    a_sfr_hold: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o)) else $error("sfr data moved");
endmodule

/* File: bench/on_chip_data_ram_cpu.sv */
// cpu side model: issues moves and sfr accesses
`timescale 1ns/1ps
module on_chip_data_ram_cpu (
    input wire logic clk_i,
    output on_chip_data_ram_pkg::on_chip_data_ram_move_s move_o,
    output on_chip_data_ram_pkg::on_chip_data_ram_sfr_s sfr_o
);
    import on_chip_data_ram_pkg::*;
    initial {move_o, sfr_o} = '0;
    task automatic mv(input logic [26:0] m);
        @(negedge clk_i);
        move_o = m;
        sfr_o[17:16] = 2'b00;
    endtask
    task automatic sf(input logic [17:0] s);
        @(negedge clk_i);
        sfr_o = s;
        move_o[26:25] = 2'b00;
    endtask
    task automatic idle;
        @(negedge clk_i);
        move_o = {2'b00, ~move_o[24:0]};
        sfr_o[17:16] = 2'b00;
    endtask
endmodule

/* File: bench/tb_top.sv */
// testbench: moves against a byte model
`timescale 1ns/1ps
module tb_top;
    import on_chip_data_ram_pkg::*;
    logic clk_i = 0, rst_n_i = 0, pss = 0;
    on_chip_data_ram_move_s move_i;
    on_chip_data_ram_sfr_s sfr_i;
    logic [7:0] mrd, srd, exp [1024];
    logic [15:0] a [32];
    logic [1:0] pg;
    logic rv, hit;
    int fail_count = 0, n_checks = 0;
    always #5 clk_i = ~clk_i;
    on_chip_data_ram_cpu on_chip_data_ram_cpu_i (.clk_i(clk_i), .move_o(move_i), .sfr_o(sfr_i));
    on_chip_data_ram_access_mapper on_chip_data_ram_access_mapper_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .move_i(move_i),
        .program_store_write_select_i(pss), .sfr_i(sfr_i), .move_rdata_o(mrd), .move_rvalid_o(rv),
        .sfr_rdata_o(srd), .sfr_hit_o(hit));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic s, input logic [15:0] ad, input logic [9:0] ix);
        on_chip_data_ram_cpu_i.mv({2'b10, s, ad, 8'h00});
        on_chip_data_ram_cpu_i.idle();
        chk(mrd, exp[ix]);
        chk({7'h00, rv}, 8'h01);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #100us;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(75));
        repeat (20) @(negedge clk_i);
        rst_n_i = 1;
        on_chip_data_ram_cpu_i.sf({2'b10, 8'h55, 8'h00});
        #1;
        chk({7'h00, hit}, 8'h00);
        on_chip_data_ram_cpu_i.sf({2'b10, 8'haf, 8'h00});
        #1;
        chk({7'h00, hit}, 8'h01);
        on_chip_data_ram_cpu_i.idle();
        chk(srd, 8'h00);
        $display("test reset read done");
        foreach (a[i])
        begin
            a[i] = 16'($urandom);
            exp[a[i][9:0]] = 8'($urandom);
            on_chip_data_ram_cpu_i.mv({3'b010, a[i], exp[a[i][9:0]]});
        end
        foreach (a[i])
            rdc(0, a[i] ^ {6'($urandom), 10'h000}, a[i][9:0]);
        $display("test alias done");
        for (int p = 0; p < 4; p++)
        begin
            pg = 2'(p);
            on_chip_data_ram_cpu_i.sf({2'b01, 8'haf, 6'($urandom), pg});
            on_chip_data_ram_cpu_i.sf({2'b10, 8'haf, 8'h00});
            exp[{pg, a[p][7:0]}] = 8'($urandom);
            on_chip_data_ram_cpu_i.mv({3'b011, a[p], exp[{pg, a[p][7:0]}]});
            chk(srd, {6'h00, pg});
            rdc(1, a[p] ^ 16'hff00, {pg, a[p][7:0]});
        end
        $display("test page done");
        pss = 1;
        on_chip_data_ram_cpu_i.mv({3'b010, a[9], ~exp[a[9][9:0]]});
        rdc(0, a[9], a[9][9:0]);
        $display("test flash yield done");
        // mid-run reset: page select clears, ram contents kept
        @(negedge clk_i);
        rst_n_i = 0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1;
        pss = 0;
        on_chip_data_ram_cpu_i.sf({2'b10, 8'haf, 8'h00});
        on_chip_data_ram_cpu_i.idle();
        chk(srd, 8'h00);
        rdc(0, a[9], a[9][9:0]);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
bind on_chip_data_ram_access_mapper on_chip_data_ram_sva on_chip_data_ram_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .move_i(move_i), .sfr_i(sfr_i),
    .move_rvalid_o(move_rvalid_o), .move_rdata_o(move_rdata_o), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o));
